// >>> src/cbfl_exec.sv
// Execution unit for branches, bit operations, flag operations and loads
// How it works
// - bit ops reach only I/O addresses 0 to 31
// - write-one clears flags; zero writes leave them
// - bit set/clear rewrites whole I/O register
// - port in/out address only 64 I/O locations
// - data address equals I/O address plus 0x20
// - extended I/O reachable only by data loads
// - taken branch adds offset, two cycles; else one
// - bit set/clear forces bit, two cycles
// - rotates move carry in, end bit out
// - arithmetic keeps bit 7; logical shifts zero-fill
// - bit to T, T to bit, one cycle
// - each flag settable and clearable alone
// - global interrupt on sets I, off clears I
// - copy, pair copy, constant load in one cycle
// - post-increment load reads then bumps pointer
// - pre-decrement load decrements then reads
// - displacement load leaves pointer untouched
`timescale 1ns/10ps
`default_nettype none
module cbfl_exec (
    input  wire logic                     CLK,
    input  wire logic                     SRST,
    input  wire logic                     INSTR_VALID,
    output logic                          INSTR_READY,
    input  wire cbfl_pkg::cbfl_op_t       INSTR_OP,
    input  wire logic [4:0]               INSTR_RD,
    input  wire logic [4:0]               INSTR_RR,
    input  wire logic [2:0]               INSTR_BIT,
    input  wire logic [1:0]               INSTR_PTR,
    input  wire cbfl_pkg::cbfl_ptr_mode_t INSTR_MODE,
    input  wire logic [15:0]              INSTR_IMM,
    output logic [15:0]                   PC_Q,
    output logic [7:0]                    FLAGS_Q,
    input  wire logic [4:0]               REG_SEL,
    output logic [7:0]                    REG_DATA_Q,
    output logic [15:0]                   MEM_ADDR_Q,
    output logic                          MEM_RD_Q,
    input  wire logic [7:0]               MEM_RDATA,
    output logic [5:0]                    IO_ADDR_Q,
    output logic                          IO_RD_Q,
    output logic                          IO_WR_Q,
    output logic [7:0]                    IO_WDATA_Q,
    input  wire logic [7:0]               IO_RDATA
);
    import cbfl_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BRANCH,
        ST_LOAD,
        ST_IO_RMW,
        ST_IO_SKIP,
        ST_IO_IN
    } cbfl_state_t;

    typedef enum logic [1:0] {
        SRC_REG,
        SRC_IO,
        SRC_MEM
    } cbfl_src_t;

    function automatic logic [4:0] ptr_lo_idx(input logic [1:0] sel);
        ptr_lo_idx = PTR_X_LO + {2'h0, sel, 1'b0};
    endfunction

    function automatic cbfl_src_t space_of(input logic [15:0] addr);
        if (addr < IO_DATA_OFFSET) begin
            space_of = SRC_REG;
        end else if (addr < EXT_IO_START) begin
            space_of = SRC_IO;
        end else begin
            space_of = SRC_MEM;
        end
    endfunction

    cbfl_state_t state_q;
    cbfl_src_t   src_q;
    logic [7:0]  rf_q [32];
    logic [4:0]  rd_q;
    logic [2:0]  bit_q;
    logic [1:0]  ptr_sel_q;
    logic        bit_op_set_q;
    logic        skip_on_one_q;
    logic [15:0] ea_q;
    logic [15:0] br_off_q;

    logic        accept;
    logic [7:0]  rd_v;
    logic [7:0]  rr_v;
    logic [4:0]  plo;
    logic [15:0] ptr_v;
    logic [15:0] ptr_hold_v;
    logic [15:0] ptr_inc;
    logic [15:0] ptr_dec;
    logic [15:0] ea;
    logic [7:0]  sh_res;
    logic        sh_c;
    logic        br_cond;
    logic [7:0]  bit_mask;
    logic [7:0]  load_val;

    assign INSTR_READY = (state_q == ST_IDLE);
    assign accept      = INSTR_VALID && INSTR_READY;
    assign rd_v        = rf_q[INSTR_RD];
    assign rr_v        = rf_q[INSTR_RR];
    assign plo         = ptr_lo_idx(INSTR_PTR);
    assign ptr_v       = {rf_q[plo | 5'h01], rf_q[plo]};
    assign ptr_hold_v  = {rf_q[ptr_lo_idx(ptr_sel_q) | 5'h01], rf_q[ptr_lo_idx(ptr_sel_q)]};
    assign ptr_inc     = ptr_v + 16'h0001;
    assign ptr_dec     = ptr_v - 16'h0001;
    assign bit_mask    = 8'h01 << bit_q;

    always_comb begin
        case (INSTR_OP)
            OP_LOAD_VIA_POINTER:    ea = (INSTR_MODE == PTR_PRE_DEC) ? ptr_dec : ptr_v;
            OP_LOAD_POINTER_OFFSET: ea = ptr_v + {10'h000, INSTR_IMM[5:0]};
            OP_LOAD_DIRECT:         ea = INSTR_IMM;
            default:                ea = ptr_v;
        endcase
    end

    always_comb begin
        case (INSTR_OP)
            OP_BRANCH_NO_OVERFLOW: br_cond = !FLAGS_Q[FLAG_V];
            OP_BRANCH_IRQ_ON:      br_cond = FLAGS_Q[FLAG_I];
            OP_BRANCH_IRQ_OFF:     br_cond = !FLAGS_Q[FLAG_I];
            default:               br_cond = 1'b0;
        endcase
    end

    always_comb begin
        case (INSTR_OP)
            OP_SHIFT_LEFT_LOGICAL: begin
                sh_res = {rd_v[6:0], 1'b0};
                sh_c   = rd_v[7];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                sh_res = {1'b0, rd_v[7:1]};
                sh_c   = rd_v[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                sh_res = {rd_v[6:0], FLAGS_Q[FLAG_C]};
                sh_c   = rd_v[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                sh_res = {FLAGS_Q[FLAG_C], rd_v[7:1]};
                sh_c   = rd_v[0];
            end
            OP_SHIFT_RIGHT_ARITH: begin
                sh_res = {rd_v[7], rd_v[7:1]};
                sh_c   = rd_v[0];
            end
            default: begin
                sh_res = rd_v;
                sh_c   = FLAGS_Q[FLAG_C];
            end
        endcase
    end

    always_comb begin
        case (src_q)
            SRC_REG: load_val = rf_q[ea_q[4:0]];
            SRC_IO:  load_val = IO_RDATA;
            default: load_val = MEM_RDATA;
        endcase
    end

    // Sequencer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        case (INSTR_OP)
                            OP_BRANCH_NO_OVERFLOW,
                            OP_BRANCH_IRQ_ON,
                            OP_BRANCH_IRQ_OFF: state_q <= br_cond ? ST_BRANCH : ST_IDLE;
                            OP_IO_BIT_SET,
                            OP_IO_BIT_CLEAR:        state_q <= ST_IO_RMW;
                            OP_SKIP_IF_IO_BIT_ONE,
                            OP_SKIP_IF_IO_BIT_ZERO: state_q <= ST_IO_SKIP;
                            OP_LOAD_VIA_POINTER,
                            OP_LOAD_POINTER_OFFSET,
                            OP_LOAD_DIRECT:         state_q <= ST_LOAD;
                            OP_PORT_IN:             state_q <= ST_IO_IN;
                            default:                state_q <= ST_IDLE;
                        endcase
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Operands held for the second cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rd_q          <= 5'h00;
            bit_q         <= 3'h0;
            ptr_sel_q     <= PTR_SEL_X;
            bit_op_set_q  <= 1'b0;
            skip_on_one_q <= 1'b0;
            ea_q          <= 16'h0000;
            br_off_q      <= 16'h0000;
            src_q         <= SRC_REG;
        end else if (accept) begin
            rd_q          <= INSTR_RD;
            bit_q         <= INSTR_BIT;
            ptr_sel_q     <= INSTR_PTR;
            bit_op_set_q  <= (INSTR_OP == OP_IO_BIT_SET);
            skip_on_one_q <= (INSTR_OP == OP_SKIP_IF_IO_BIT_ONE);
            ea_q          <= ea;
            br_off_q      <= {{9{INSTR_IMM[6]}}, INSTR_IMM[6:0]};
            src_q         <= space_of(ea);
        end
    end

    // Program counter
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PC_Q <= PC_RESET;
        end else if (accept) begin
            PC_Q <= PC_Q + ((INSTR_OP == OP_LOAD_DIRECT) ? PC_STEP_DBL : PC_STEP);
        end else if (state_q == ST_BRANCH) begin
            PC_Q <= PC_Q + br_off_q;
        end else if (state_q == ST_IO_SKIP && (IO_RDATA[bit_q] == skip_on_one_q)) begin
            PC_Q <= PC_Q + PC_STEP;
        end
    end

    // Status flags
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FLAGS_Q <= FLAGS_RESET;
        end else if (accept) begin
            case (INSTR_OP)
                OP_SHIFT_LEFT_LOGICAL,
                OP_SHIFT_RIGHT_LOGICAL,
                OP_ROTATE_LEFT_CARRY,
                OP_ROTATE_RIGHT_CARRY,
                OP_SHIFT_RIGHT_ARITH: begin
                    FLAGS_Q[FLAG_Z] <= (sh_res == 8'h00);
                    FLAGS_Q[FLAG_C] <= sh_c;
                    FLAGS_Q[FLAG_N] <= sh_res[7];
                    FLAGS_Q[FLAG_V] <= sh_res[7] ^ sh_c;
                end
                OP_FLAG_SET:       FLAGS_Q[INSTR_BIT] <= 1'b1;
                OP_FLAG_CLEAR:     FLAGS_Q[INSTR_BIT] <= 1'b0;
                OP_BIT_TO_T_FLAG:  FLAGS_Q[FLAG_T] <= rr_v[INSTR_BIT];
                OP_IRQ_GLOBAL_ON:  FLAGS_Q[FLAG_I] <= 1'b1;
                OP_IRQ_GLOBAL_OFF: FLAGS_Q[FLAG_I] <= 1'b0;
                default:           FLAGS_Q <= FLAGS_Q;
            endcase
        end
    end

    // Register file
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= 8'h00;
            end
        end else if (accept) begin
            case (INSTR_OP)
                OP_SHIFT_LEFT_LOGICAL,
                OP_SHIFT_RIGHT_LOGICAL,
                OP_ROTATE_LEFT_CARRY,
                OP_ROTATE_RIGHT_CARRY,
                OP_SHIFT_RIGHT_ARITH: rf_q[INSTR_RD] <= sh_res;
                OP_T_FLAG_TO_BIT:     rf_q[INSTR_RD][INSTR_BIT] <= FLAGS_Q[FLAG_T];
                OP_REG_COPY:          rf_q[INSTR_RD] <= rr_v;
                OP_REG_PAIR_COPY: begin
                    rf_q[{INSTR_RD[4:1], 1'b0}] <= rf_q[{INSTR_RR[4:1], 1'b0}];
                    rf_q[{INSTR_RD[4:1], 1'b1}] <= rf_q[{INSTR_RR[4:1], 1'b1}];
                end
                OP_LOAD_CONSTANT:     rf_q[INSTR_RD] <= INSTR_IMM[7:0];
                OP_LOAD_VIA_POINTER: begin
                    if (INSTR_MODE == PTR_POST_INC) begin
                        rf_q[plo]         <= ptr_inc[7:0];
                        rf_q[plo | 5'h01] <= ptr_inc[15:8];
                    end else if (INSTR_MODE == PTR_PRE_DEC) begin
                        rf_q[plo]         <= ptr_dec[7:0];
                        rf_q[plo | 5'h01] <= ptr_dec[15:8];
                    end
                end
                default: rf_q[0] <= rf_q[0];
            endcase
        end else if (state_q == ST_LOAD) begin
            rf_q[rd_q] <= load_val;
        end else if (state_q == ST_IO_IN) begin
            rf_q[rd_q] <= IO_RDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            REG_DATA_Q <= 8'h00;
        end else begin
            REG_DATA_Q <= rf_q[REG_SEL];
        end
    end

    // Data memory port
    always_ff @(posedge CLK) begin
        if (SRST) begin
            MEM_ADDR_Q <= 16'h0000;
            MEM_RD_Q   <= 1'b0;
        end else begin
            MEM_RD_Q <= 1'b0;
            if (accept && space_of(ea) == SRC_MEM && (INSTR_OP == OP_LOAD_VIA_POINTER ||
                INSTR_OP == OP_LOAD_POINTER_OFFSET || INSTR_OP == OP_LOAD_DIRECT)) begin
                MEM_ADDR_Q <= ea;
                MEM_RD_Q   <= 1'b1;
            end
        end
    end

    // I/O port
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IO_ADDR_Q  <= 6'h00;
            IO_RD_Q    <= 1'b0;
            IO_WR_Q    <= 1'b0;
            IO_WDATA_Q <= 8'h00;
        end else begin
            IO_RD_Q <= 1'b0;
            IO_WR_Q <= 1'b0;
            if (accept) begin
                case (INSTR_OP)
                    OP_IO_BIT_SET,
                    OP_IO_BIT_CLEAR,
                    OP_SKIP_IF_IO_BIT_ONE,
                    OP_SKIP_IF_IO_BIT_ZERO: begin
                        IO_ADDR_Q <= {1'b0, INSTR_IMM[4:0]};
                        IO_RD_Q   <= 1'b1;
                    end
                    OP_PORT_IN: begin
                        IO_ADDR_Q <= INSTR_IMM[5:0];
                        IO_RD_Q   <= 1'b1;
                    end
                    OP_PORT_OUT: begin
                        IO_ADDR_Q  <= INSTR_IMM[5:0];
                        IO_WR_Q    <= 1'b1;
                        IO_WDATA_Q <= rr_v;
                    end
                    OP_LOAD_VIA_POINTER,
                    OP_LOAD_POINTER_OFFSET,
                    OP_LOAD_DIRECT: begin
                        if (space_of(ea) == SRC_IO) begin
                            IO_ADDR_Q <= 6'(ea - IO_DATA_OFFSET);
                            IO_RD_Q   <= 1'b1;
                        end
                    end
                    default: IO_ADDR_Q <= IO_ADDR_Q;
                endcase
            end else if (state_q == ST_IO_RMW) begin
                // Whole register written back, so set W1C flags read as one get cleared
                IO_WR_Q    <= 1'b1;
                IO_WDATA_Q <= bit_op_set_q ? IO_RDATA | bit_mask : IO_RDATA & ~bit_mask;
            end
        end
    end

    sequence branch_taken_s;
        accept && INSTR_OP inside {OP_BRANCH_NO_OVERFLOW, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF}
            && br_cond;
    endsequence

    sequence load_issue_s;
        accept && INSTR_OP inside {OP_LOAD_VIA_POINTER, OP_LOAD_POINTER_OFFSET, OP_LOAD_DIRECT};
    endsequence

    branch_taken_pc_a: assert property (@(posedge CLK) disable iff (SRST)
        branch_taken_s |=> !INSTR_READY ##1 INSTR_READY && PC_Q == $past(PC_Q, 2) + 16'h0001 +
        {{9{$past(INSTR_IMM[6], 2)}}, $past(INSTR_IMM[6:0], 2)})
        else $error("taken branch target or timing wrong");

    branch_skip_pc_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_BRANCH_NO_OVERFLOW && FLAGS_Q[FLAG_V]
        |=> INSTR_READY && PC_Q == $past(PC_Q) + 16'h0001 && FLAGS_Q == $past(FLAGS_Q))
        else $error("untaken branch wrong");

    io_bit_range_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR}
        |=> IO_RD_Q && IO_ADDR_Q == {1'b0, $past(INSTR_IMM[4:0])} ##1 IO_WR_Q && INSTR_READY)
        else $error("io bit op address or timing wrong");

    io_rmw_data_a: assert property (@(posedge CLK) disable iff (SRST)
        state_q == ST_IO_RMW && bit_op_set_q |=> IO_WDATA_Q == ($past(IO_RDATA) | $past(bit_mask)))
        else $error("read-modify-write data wrong");

    io_offset_map_a: assert property (@(posedge CLK) disable iff (SRST)
        load_issue_s and (accept && ea >= IO_DATA_OFFSET && ea < EXT_IO_START)
        |=> IO_RD_Q && !MEM_RD_Q && IO_ADDR_Q == 6'($past(ea) - IO_DATA_OFFSET))
        else $error("data space to io mapping wrong");

    ext_io_mem_a: assert property (@(posedge CLK) disable iff (SRST)
        load_issue_s and (accept && ea >= EXT_IO_START) |=> MEM_RD_Q && !IO_RD_Q)
        else $error("extended io not routed to memory");

    rotate_carry_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_ROTATE_LEFT_CARRY |=> FLAGS_Q[FLAG_C] == $past(rd_v[7]) &&
        rf_q[rd_q][0] == $past(FLAGS_Q[FLAG_C]) &&
        FLAGS_Q[FLAG_V] == (FLAGS_Q[FLAG_N] ^ FLAGS_Q[FLAG_C]))
        else $error("rotate left wrong");

    bit_to_t_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_BIT_TO_T_FLAG |=> FLAGS_Q[FLAG_T] == $past(rr_v[INSTR_BIT]))
        else $error("T flag not loaded");

    flag_set_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_FLAG_SET
        |=> FLAGS_Q == ($past(FLAGS_Q) | (8'h01 << $past(INSTR_BIT))))
        else $error("flag set touched other flags");

    reg_copy_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_REG_COPY |=> INSTR_READY && rf_q[rd_q] == $past(rr_v))
        else $error("register copy wrong");

    post_inc_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_LOAD_VIA_POINTER && INSTR_MODE == PTR_POST_INC
        |=> ptr_hold_v == $past(ptr_v) + 16'h0001 && ea_q == $past(ptr_v) ##1 INSTR_READY)
        else $error("post increment load wrong");

    disp_hold_a: assert property (@(posedge CLK) disable iff (SRST)
        accept && INSTR_OP == OP_LOAD_POINTER_OFFSET
        |=> ptr_hold_v == $past(ptr_v) ##1 INSTR_READY)
        else $error("displacement load moved pointer");
endmodule
`default_nettype wire

// >>> src/cbfl_pkg.sv
// Package for the bit, flag and load execution unit: operations, flags and address map
package cbfl_pkg;
    typedef enum logic [4:0] {
        OP_NOP,
        OP_BRANCH_NO_OVERFLOW,
        OP_BRANCH_IRQ_ON,
        OP_BRANCH_IRQ_OFF,
        OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR,
        OP_SKIP_IF_IO_BIT_ONE,
        OP_SKIP_IF_IO_BIT_ZERO,
        OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_ARITH,
        OP_FLAG_SET,
        OP_FLAG_CLEAR,
        OP_BIT_TO_T_FLAG,
        OP_T_FLAG_TO_BIT,
        OP_IRQ_GLOBAL_ON,
        OP_IRQ_GLOBAL_OFF,
        OP_REG_COPY,
        OP_REG_PAIR_COPY,
        OP_LOAD_CONSTANT,
        OP_LOAD_VIA_POINTER,
        OP_LOAD_POINTER_OFFSET,
        OP_LOAD_DIRECT,
        OP_PORT_IN,
        OP_PORT_OUT
    } cbfl_op_t;

    typedef enum logic [1:0] {
        PTR_PLAIN,
        PTR_POST_INC,
        PTR_PRE_DEC
    } cbfl_ptr_mode_t;

    // Pointer select codes
    localparam logic [1:0] PTR_SEL_X = 2'h0;
    localparam logic [1:0] PTR_SEL_Y = 2'h1;
    localparam logic [1:0] PTR_SEL_Z = 2'h2;
    localparam logic [4:0] PTR_X_LO  = 5'h1a;

    // Bit positions in status_flags_reg
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Data space map
    localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
    localparam logic [15:0] EXT_IO_START   = 16'h0060;
    localparam logic [15:0] EXT_IO_END     = 16'h01ff;

    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [15:0] PC_STEP     = 16'h0001;
    localparam logic [15:0] PC_STEP_DBL = 16'h0002;
endpackage

// >>> test/cbfl_mem_model.sv
// Behavioural data memory and I/O register space facing the execution unit
`timescale 1ns/10ps
`default_nettype none
module cbfl_mem_model #(
    parameter logic [5:0] W1C_ADDR = 6'h16
) (
    input  wire logic [15:0] MEM_ADDR,
    input  wire logic        CLK,
    input  wire logic        MEM_RD,
    output logic      [7:0]  MEM_RDATA,
    input  wire logic [5:0]  IO_ADDR,
    input  wire logic        IO_RD,
    input  wire logic        IO_WR,
    input  wire logic [7:0]  IO_WDATA,
    output logic      [7:0]  IO_RDATA
);
    logic [7:0] io_q [64];
    logic [7:0] wr_data_q;
    logic [5:0] wr_addr_q;
    // Outside a read strobe the buses show inverted data, so stale values never match
    assign MEM_RDATA = MEM_RD ? (MEM_ADDR[7:0] ^ 8'h3c) : ~(MEM_ADDR[7:0] ^ 8'h3c);
    assign IO_RDATA  = IO_RD ? io_q[IO_ADDR] : ~io_q[IO_ADDR];
    initial begin
        for (int i = 0; i < 64; i++) begin
            io_q[i] = 8'ha5;
        end
        io_q[W1C_ADDR] = 8'h05;
        wr_data_q = 8'h00;
        wr_addr_q = 6'h00;
    end
    always @(posedge CLK) begin
        if (IO_WR) begin
            wr_addr_q <= IO_ADDR;
            wr_data_q <= IO_WDATA;
            if (IO_ADDR == W1C_ADDR) begin
                io_q[IO_ADDR] <= io_q[IO_ADDR] & ~IO_WDATA;
            end else begin
                io_q[IO_ADDR] <= IO_WDATA;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/cbfl_exec_tb_top.sv
// Self-checking bench for the bit, flag and load execution unit
`timescale 1ns/10ps
`default_nettype none
module cbfl_exec_tb_top;
    import cbfl_pkg::*;
    logic           clk, srst, valid, ready, mem_rd, io_rd, io_wr;
    logic [4:0]     rd, rr, reg_sel;
    logic [2:0]     bt;
    logic [1:0]     ptr;
    logic [15:0]    imm, pc, mem_addr, p;
    logic [7:0]     flags, reg_data, mem_rdata, io_wdata, io_rdata, f;
    logic [5:0]     io_addr;
    cbfl_op_t       op;
    cbfl_ptr_mode_t mode;
    int             bad_count, check_count, ncyc;
    cbfl_op_t       sh_op [5] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH};
    logic [7:0]     sh_in [5] = '{8'h81, 8'h02, 8'h40, 8'h01, 8'h82};
    logic [7:0]     sh_res [5] = '{8'h02, 8'h01, 8'h81, 8'h80, 8'hc1};
    logic           sh_c [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    // Pointer loads carry pointer select and mode in the source register field
    assign ptr  = rr[1:0];
    assign mode = cbfl_ptr_mode_t'(rr[3:2]);
    cbfl_exec DUT (.CLK(clk), .SRST(srst), .INSTR_VALID(valid), .INSTR_READY(ready),
        .INSTR_OP(op), .INSTR_RD(rd), .INSTR_RR(rr), .INSTR_BIT(bt), .INSTR_PTR(ptr),
        .INSTR_MODE(mode), .INSTR_IMM(imm), .PC_Q(pc), .FLAGS_Q(flags), .REG_SEL(reg_sel),
        .REG_DATA_Q(reg_data), .MEM_ADDR_Q(mem_addr), .MEM_RD_Q(mem_rd),
        .MEM_RDATA(mem_rdata), .IO_ADDR_Q(io_addr), .IO_RD_Q(io_rd), .IO_WR_Q(io_wr),
        .IO_WDATA_Q(io_wdata), .IO_RDATA(io_rdata));
    cbfl_mem_model MDL (.CLK(clk), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
        .MEM_RDATA(mem_rdata), .IO_ADDR(io_addr), .IO_RD(io_rd), .IO_WR(io_wr),
        .IO_WDATA(io_wdata), .IO_RDATA(io_rdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic test_done();
        $display("bad_count=%0d check_count=%0d", bad_count, check_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Offers one instruction, returns at a settled point once ready again
    task automatic iss(input cbfl_op_t o, input logic [4:0] d, input logic [4:0] r,
                       input logic [2:0] b, input logic [15:0] k);
        logic rdy;
        rdy = 1'b0;
        @(posedge clk);
        op <= o;
        rd <= d;
        rr <= r;
        bt <= b;
        imm <= k;
        valid <= 1'b1;
        for (int i = 0; i < 20 && !rdy; i++) begin
            @(negedge clk) rdy = ready;
            @(posedge clk);
        end
        valid <= 1'b0;
        ncyc = 1;
        @(negedge clk);
        while (!ready && ncyc < 20) begin
            ncyc++;
            @(negedge clk);
        end
        if (!rdy || !ready) begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic creg(input logic [4:0] idx, input logic [7:0] e);
        @(posedge clk);
        reg_sel <= idx;
        @(posedge clk);
        @(negedge clk);
        chk(16'(reg_data), 16'(e));
    endtask
    task automatic t_flags();
        for (int b = 0; b < 8; b++) begin
            iss(OP_FLAG_SET, 5'h00, 5'h00, 3'(b), 16'h0000);
            f[b] = 1'b1;
            chk(16'(flags), 16'(f));
        end
        for (int b = 0; b < 8; b++) begin
            iss(OP_FLAG_CLEAR, 5'h00, 5'h00, 3'(b), 16'h0000);
            f[b] = 1'b0;
            chk(16'(flags), 16'(f));
            chk(16'(ncyc), 16'h0001);
        end
        iss(OP_IRQ_GLOBAL_ON, 5'h00, 5'h00, 3'h0, 16'h0000);
        chk(16'(flags), 16'h0080);
        iss(OP_IRQ_GLOBAL_OFF, 5'h00, 5'h00, 3'h0, 16'h0000);
        chk(16'(flags), 16'h0000);
    endtask
    task automatic t_moves();
        iss(OP_LOAD_CONSTANT, 5'h10, 5'h00, 3'h0, 16'h0081);
        iss(OP_REG_COPY, 5'h11, 5'h10, 3'h0, 16'h0000);
        chk(16'(ncyc), 16'h0001);
        iss(OP_LOAD_CONSTANT, 5'h12, 5'h00, 3'h0, 16'h003c);
        iss(OP_LOAD_CONSTANT, 5'h13, 5'h00, 3'h0, 16'h007e);
        iss(OP_REG_PAIR_COPY, 5'h14, 5'h12, 3'h0, 16'h0000);
        creg(5'h11, 8'h81);
        creg(5'h14, 8'h3c);
        creg(5'h15, 8'h7e);
        chk(16'(flags), 16'h0000);
    endtask
    task automatic t_shifts();
        for (int i = 0; i < 5; i++) begin
            iss(OP_LOAD_CONSTANT, 5'h10, 5'h00, 3'h0, 16'(sh_in[i]));
            iss(OP_FLAG_SET, 5'h00, 5'h00, 3'h0, 16'h0000);
            iss(sh_op[i], 5'h10, 5'h00, 3'h0, 16'h0000);
            chk(16'(ncyc), 16'h0001);
            chk(16'(flags[FLAG_C]), 16'(sh_c[i]));
            creg(5'h10, sh_res[i]);
        end
    endtask
    task automatic t_tflag();
        iss(OP_LOAD_CONSTANT, 5'h10, 5'h00, 3'h0, 16'h0040);
        iss(OP_BIT_TO_T_FLAG, 5'h10, 5'h10, 3'h6, 16'h0000);
        chk(16'(flags[FLAG_T]), 16'h0001);
        iss(OP_T_FLAG_TO_BIT, 5'h11, 5'h11, 3'h3, 16'h0000);
        creg(5'h11, 8'h89);
        iss(OP_BIT_TO_T_FLAG, 5'h10, 5'h10, 3'h0, 16'h0000);
        chk(16'(flags[FLAG_T]), 16'h0000);
        iss(OP_T_FLAG_TO_BIT, 5'h11, 5'h11, 3'h7, 16'h0000);
        chk(16'(ncyc), 16'h0001);
        creg(5'h11, 8'h09);
    endtask
    task automatic t_branch();
        iss(OP_IRQ_GLOBAL_ON, 5'h00, 5'h00, 3'h0, 16'h0000);
        iss(OP_FLAG_SET, 5'h00, 5'h00, 3'(FLAG_V), 16'h0000);
        p = pc;
        f = flags;
        iss(OP_BRANCH_IRQ_ON, 5'h00, 5'h00, 3'h0, 16'h007e);
        chk(pc, p - 16'h0001);
        chk(16'(ncyc), 16'h0002);
        iss(OP_BRANCH_NO_OVERFLOW, 5'h00, 5'h00, 3'h0, 16'h0005);
        iss(OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, 3'h0, 16'h0005);
        chk(pc, p + 16'h0001);
        chk(16'(ncyc), 16'h0001);
        chk(16'(flags), 16'(f));
        iss(OP_FLAG_CLEAR, 5'h00, 5'h00, 3'(FLAG_V), 16'h0000);
        iss(OP_IRQ_GLOBAL_OFF, 5'h00, 5'h00, 3'h0, 16'h0000);
        p = pc;
        iss(OP_BRANCH_NO_OVERFLOW, 5'h00, 5'h00, 3'h0, 16'h0005);
        iss(OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, 3'h0, 16'h0005);
        chk(pc, p + 16'h000c);
        chk(16'(ncyc), 16'h0002);
    endtask
    task automatic t_io();
        iss(OP_IO_BIT_SET, 5'h00, 5'h00, 3'h7, 16'h0016);
        chk(16'(ncyc), 16'h0002);
        @(negedge clk);
        chk(16'(MDL.wr_data_q), 16'h0085);
        chk(16'(MDL.io_q[22]), 16'h0000);
        iss(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 3'h0, 16'h0025);
        chk(16'(io_addr), 16'h0005);
        @(negedge clk);
        chk(16'(MDL.wr_data_q), 16'h00a4);
        p = pc;
        iss(OP_SKIP_IF_IO_BIT_ONE, 5'h00, 5'h00, 3'h2, 16'h0005);
        chk(pc, p + 16'h0002);
        iss(OP_PORT_IN, 5'h12, 5'h00, 3'h0, 16'h0005);
        creg(5'h12, 8'ha4);
        iss(OP_LOAD_DIRECT, 5'h13, 5'h00, 3'h0, 16'h0025);
        chk(16'(io_addr), 16'h0005);
        creg(5'h13, 8'ha4);
        iss(OP_PORT_OUT, 5'h00, 5'h13, 3'h0, 16'h003f);
        @(negedge clk);
        chk({10'h000, MDL.wr_addr_q}, 16'h003f);
        iss(OP_LOAD_DIRECT, 5'h14, 5'h00, 3'h0, 16'h0060);
        chk(mem_addr, 16'h0060);
        creg(5'h14, 8'h5c);
    endtask
    task automatic t_ptr();
        iss(OP_LOAD_CONSTANT, 5'h1a, 5'h00, 3'h0, 16'h00ff);
        iss(OP_LOAD_CONSTANT, 5'h1b, 5'h00, 3'h0, 16'h0000);
        iss(OP_LOAD_VIA_POINTER, 5'h10, 5'h04, 3'h0, 16'h0000);
        chk(mem_addr, 16'h00ff);
        chk(16'(ncyc), 16'h0002);
        creg(5'h10, 8'hc3);
        creg(5'h1b, 8'h01);
        iss(OP_LOAD_CONSTANT, 5'h1c, 5'h00, 3'h0, 16'h0000);
        iss(OP_LOAD_CONSTANT, 5'h1d, 5'h00, 3'h0, 16'h0001);
        iss(OP_LOAD_VIA_POINTER, 5'h11, 5'h09, 3'h0, 16'h0000);
        chk(mem_addr, 16'h00ff);
        creg(5'h1c, 8'hff);
        creg(5'h1d, 8'h00);
        iss(OP_LOAD_CONSTANT, 5'h1f, 5'h00, 3'h0, 16'h0002);
        iss(OP_LOAD_POINTER_OFFSET, 5'h12, 5'h02, 3'h0, 16'h003f);
        chk(mem_addr, 16'h023f);
        creg(5'h12, 8'h03);
        creg(5'h1f, 8'h02);
    endtask
    initial begin
        {srst, valid, rd, rr, bt, imm, reg_sel, f} = {1'b1, 43'h0};
        op = OP_NOP;
        bad_count = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(pc, PC_RESET);
        t_flags();
        t_moves();
        t_shifts();
        t_tflag();
        t_branch();
        t_io();
        t_ptr();
        test_done();
    end
endmodule
`default_nettype wire
